// file: dv/ext_programmer.sv
// External programmer and program-flash model on the far side of the block
`timescale 1ns/1ps
module ext_programmer (
   input  wire logic        pclk,
   input  wire logic [13:0] ext_rdata,
   output logic             ext_prog_active,
   output logic             lvp_entry,
   output logic             bulk_erase,
   output logic [15:0]      ext_addr,
   output logic             ext_wr_en,
   output logic [13:0]      ext_wdata,
   output logic             ext_rd_en,
   output logic [13:0]      ext_mem_rdata
);
   // Flash content is a fixed pattern, so the bench knows every word
   assign ext_mem_rdata = 14'h2a00 ^ ext_addr[13:0];

   initial begin
      ext_prog_active = 1'b1;
      lvp_entry       = 1'b0;
      bulk_erase      = 1'b0;
      ext_addr        = 16'h0000;
      ext_wr_en       = 1'b0;
      ext_wdata       = 14'h0000;
      ext_rd_en       = 1'b0;
   end

   // One request per call; lines are inverted after release, not kept
   task automatic access(input logic wr, input logic [15:0] a,
                         input logic [13:0] d, output logic [13:0] q);
      @(posedge pclk);
      ext_addr  <= a;
      ext_wdata <= d;
      ext_wr_en <= wr;
      ext_rd_en <= ~wr;
      @(posedge pclk);
      ext_wr_en <= 1'b0;
      ext_rd_en <= 1'b0;
      ext_addr  <= ~a;
      ext_wdata <= ~d;
      #1 q = ext_rdata;
   endtask

   task automatic erase();
      @(posedge pclk);
      bulk_erase <= 1'b1;
      @(posedge pclk);
      bulk_erase <= 1'b0;
      @(posedge pclk);
   endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the configuration word decode block
`timescale 1ns/1ps
module tb_top;
   import cfg_pkg::*;
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic [15:0] paddr, ext_addr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, ext_prog_active, lvp_entry;
   logic        bulk_erase, ext_wr_en, ext_rd_en, cpu_rd_en;
   logic [13:0] ext_wdata, ext_mem_rdata, ext_rdata, q;
   logic [13:0] cpu_mem_rdata, cpu_rdata;
   logic        ext_mem_wr_allow, ext_wr_refused, in_sleep;
   logic        soft_brownout_on, soft_watchdog_on, reset_pin_pullup_on;
   logic        clock_out_on, brownout_active, powerup_timer_on;
   logic        watchdog_active, clock_input_pin_io, master_clear_pin_reset;
   logic        master_clear_pin_pullup, low_power_brownout_on;
   logic        brownout_trip_low, stack_fault_reset_on;
   logic        code_protect_on, low_voltage_prog_on;
   mode_t       brownout_mode, watchdog_mode;
   osc_t        oscillator_select;
   int          mismatches, n_checks;

   config_word_protection_decode config_word_protection_decode_inst (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_prog_active, .lvp_entry,
      .bulk_erase, .ext_addr, .ext_wr_en, .ext_wdata, .ext_rd_en,
      .ext_mem_rdata, .ext_rdata, .ext_mem_wr_allow, .ext_wr_refused,
      .cpu_rd_en, .cpu_mem_rdata, .cpu_rdata, .soft_brownout_on,
      .soft_watchdog_on, .reset_pin_pullup_on, .in_sleep, .clock_out_on,
      .brownout_active, .brownout_mode, .powerup_timer_on,
      .watchdog_active, .watchdog_mode, .oscillator_select,
      .clock_input_pin_io, .master_clear_pin_reset,
      .master_clear_pin_pullup, .low_power_brownout_on,
      .brownout_trip_low, .stack_fault_reset_on, .code_protect_on,
      .low_voltage_prog_on);

   ext_programmer ext_programmer_inst (
      .pclk, .ext_rdata, .ext_prog_active, .lvp_entry, .bulk_erase,
      .ext_addr, .ext_wr_en, .ext_wdata, .ext_rd_en, .ext_mem_rdata);

   always #5 pclk = ~pclk;

   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done();
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Master waits for pready with a bounded count, never a fixed latency
   task automatic apb(input logic wr, input logic [15:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk("pready", 32'h1, 32'(pready));
   endtask

   task automatic ext(input logic wr, input logic [15:0] a,
                      input logic [13:0] d);
      ext_programmer_inst.access(wr, a, d, q);
   endtask

   task automatic t_blank();
      chk("clock_out_on", 32'h0, 32'(clock_out_on));
      chk("bor_mode", 32'(MODE_ALWAYS), 32'(brownout_mode));
      chk("powerup_timer_on", 32'h0, 32'(powerup_timer_on));
      chk("wdt_mode", 32'(MODE_ALWAYS), 32'(watchdog_mode));
      chk("osc", 32'(OSC_EXT_HIGH), 32'(oscillator_select));
      chk("clock_input_pin_io", 32'h0, 32'(clock_input_pin_io));
      chk("master_clear_pin_reset", 32'h1, 32'(master_clear_pin_reset));
      chk("master_clear_pin_pull", 32'h1, 32'(master_clear_pin_pullup));
      chk("low_power_brownout_off_on", 32'h0, 32'(low_power_brownout_on));
      chk("trip_low", 32'h1, 32'(brownout_trip_low));
      chk("stack_rst", 32'h1, 32'(stack_fault_reset_on));
      chk("lvp_on", 32'h1, 32'(low_voltage_prog_on));
      chk("cp_on", 32'h0, 32'(code_protect_on));
      in_sleep <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("bor_sleep", 32'h1, 32'(brownout_active));
      chk("wdt_sleep", 32'h1, 32'(watchdog_active));
      in_sleep <= 1'b0;
      ext(1'b0, ADDR_CFG_ONE, 14'h0);
      chk("word_one", 32'(CFG_BLANK), 32'(q));
      ext(1'b0, ADDR_CFG_TWO, 14'h0);
      chk("word_two", 32'(CFG_BLANK), 32'(q));
   endtask

   task automatic t_regs();
      apb(1'b0, REG_USER_ID + 16'h4, 32'h0);
      chk("uid1_rst", 32'(USER_ID_RESET), rd);
      apb(1'b1, REG_USER_ID, 32'h0000_1234);
      apb(1'b0, REG_USER_ID, 32'h0);
      chk("uid0", 32'h0000_1234, rd);
      ext(1'b0, ADDR_USER_ID0, 14'h0);
      chk("uid0_ext", 32'h0000_1234, 32'(q));
      apb(1'b1, REG_CFG_ONE, 32'h0);
      chk("ro_err", 32'h1, 32'(err));
      apb(1'b0, REG_CFG_ONE, 32'h0);
      chk("ro_kept", 32'(CFG_BLANK), rd);
      apb(1'b0, 16'h0040, 32'h0);
      chk("unmapped_err", 32'h1, 32'(err));
   endtask

   task automatic t_protect();
      ext(1'b0, 16'h0123, 14'h0);
      chk("prog_rd", 32'h0000_2b23, 32'(q));
      ext(1'b1, 16'h0123, 14'h0055);
      chk("wr_allow", 32'h1, 32'(ext_mem_wr_allow));
      ext(1'b1, ADDR_CFG_TWO, 14'h0);
      ext(1'b0, ADDR_CFG_TWO, 14'h0);
      chk("w2_fixed", 32'(CFG_TWO_FIXED), 32'(q));
      ext(1'b1, ADDR_CFG_ONE, 14'h3f7f);
      apb(1'b0, REG_CFG_ONE, 32'h0);
      chk("w1_apb", 32'h0000_3f7f, rd);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("cp_stored", 32'h1, 32'(rd[2]));
      ext(1'b0, 16'h0123, 14'h0);
      chk("prot_rd", 32'h0, 32'(q));
      ext(1'b1, 16'h0123, 14'h0055);
      chk("prot_refuse", 32'h1, 32'(ext_wr_refused));
      chk("prot_allow", 32'h0, 32'(ext_mem_wr_allow));
      @(posedge pclk);
      cpu_rd_en     <= 1'b1;
      cpu_mem_rdata <= 14'h1555;
      @(posedge pclk);
      cpu_rd_en     <= 1'b0;
      cpu_mem_rdata <= 14'h2aaa;
      #1 chk("cpu_rd", 32'h0000_1555, 32'(cpu_rdata));
      chk("cp_held", 32'h0, 32'(code_protect_on));
      ext(1'b1, ADDR_CFG_ONE, 14'h3fff);
      ext(1'b0, ADDR_CFG_ONE, 14'h0);
      chk("cp_sticky", 32'h0000_3f7f, 32'(q));
      ext(1'b0, ADDR_USER_ID0, 14'h0);
      chk("uid_prot", 32'h0000_1234, 32'(q));
   endtask

   task automatic t_erase_lvp();
      ext_programmer_inst.erase();
      ext(1'b0, ADDR_CFG_ONE, 14'h0);
      chk("erase_w1", 32'(CFG_BLANK), 32'(q));
      ext(1'b0, 16'h0123, 14'h0);
      chk("erase_rd", 32'h0000_2b23, 32'(q));
      apb(1'b0, REG_USER_ID, 32'h0);
      chk("erase_uid", 32'(USER_ID_RESET), rd);
      ext_programmer_inst.lvp_entry <= 1'b1;
      ext(1'b1, ADDR_CFG_TWO, 14'h0);
      chk("lvp_refuse", 32'h1, 32'(ext_wr_refused));
      ext(1'b0, ADDR_CFG_TWO, 14'h0);
      chk("lvp_kept", 32'h0000_31fc, 32'(q));
      ext_programmer_inst.lvp_entry <= 1'b0;
      // Guard stays open while the latched word is blank
      apb(1'b1, REG_PROBE, 32'h0000_0000);
      apb(1'b0, REG_PROBE_RES, 32'h0);
      chk("guard_000", 32'h0, 32'(rd[0]));
      apb(1'b1, REG_PROBE, 32'(GUARD_LIM_00));
      apb(1'b0, REG_PROBE_RES, 32'h0);
      chk("guard_7ff", 32'h0, 32'(rd[0]));
   endtask

   task automatic t_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask

   // Stored words reach the outputs only through a reset
   task automatic t_decode();
      ext(1'b1, ADDR_CFG_ONE, 14'h0);
      chk("held_cp", 32'h0, 32'(code_protect_on));
      t_reset();
      chk("d_clock_output_pin", 32'h1, 32'(clock_out_on));
      chk("d_bor", 32'(MODE_OFF), 32'(brownout_mode));
      chk("d_bor_act", 32'h0, 32'(brownout_active));
      chk("d_powerup_timer", 32'h1, 32'(powerup_timer_on));
      chk("d_wdt", 32'(MODE_OFF), 32'(watchdog_mode));
      chk("d_osc", 32'(OSC_INTERNAL), 32'(oscillator_select));
      chk("d_clock_input_pin", 32'h1, 32'(clock_input_pin_io));
      chk("d_master_clear_pin", 32'h1, 32'(master_clear_pin_reset));
      chk("d_low_power_brownout_off", 32'h1, 32'(low_power_brownout_on));
      chk("d_trip", 32'h0, 32'(brownout_trip_low));
      chk("d_stack", 32'h0, 32'(stack_fault_reset_on));
      chk("d_cp", 32'h1, 32'(code_protect_on));
      apb(1'b1, REG_PROBE, 32'(GUARD_LIM_00));
      apb(1'b0, REG_PROBE_RES, 32'h0);
      chk("d_guard_in", 32'h1, 32'(rd[0]));
      apb(1'b1, REG_PROBE, 32'h0000_0800);
      apb(1'b0, REG_PROBE_RES, 32'h0);
      chk("d_guard_out", 32'h0, 32'(rd[0]));
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      cpu_rd_en = 1'b0;
      cpu_mem_rdata = 14'h0;
      in_sleep = 1'b0;
      soft_brownout_on = 1'b0;
      soft_watchdog_on = 1'b0;
      reset_pin_pullup_on = 1'b1;
      mismatches = 0;
      n_checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      // Flash starts unknown: erase it, then reset to latch the blank
      ext_programmer_inst.erase();
      t_reset();
      t_blank();
      t_regs();
      t_protect();
      t_erase_lvp();
      t_decode();
      test_done();
   end

   // Whole run takes about 140 cycles; this 2000-cycle limit is far above it
   initial begin
      #20000;
      mismatches++;
      test_done();
   end
endmodule

// file: rtl/cfg_pkg.sv
// Constants for the configuration word decode block
package cfg_pkg;
   // Program-space addresses
   localparam logic [15:0] ADDR_USER_ID0   = 16'h8000;
   localparam logic [15:0] ADDR_USER_ID3   = 16'h8003;
   localparam logic [15:0] ADDR_CFG_ONE    = 16'h8007;
   localparam logic [15:0] ADDR_CFG_TWO    = 16'h8008;
   localparam int          CFG_W           = 14;
   localparam logic [13:0] CFG_BLANK       = 14'h3fff;
   // Bits that always read as one
   localparam logic [13:0] CFG_ONE_FIXED   = 14'h3104;
   localparam logic [13:0] CFG_TWO_FIXED   = 14'h11fc;
   // Word one fields
   localparam int CLOCK_OUTPUT_PIN_BIT   = 11;
   localparam int BOR_LSB      = 9;
   localparam int CP_BIT       = 7;
   localparam int RSTPIN_BIT   = 6;
   localparam int POWERUP_TIMER_BIT     = 5;
   localparam int WDT_LSB      = 3;
   localparam int OSC_LSB      = 0;
   // Word two fields
   localparam int LVP_BIT      = 13;
   localparam int LOW_POWER_BROWNOUT_OFF_BIT    = 11;
   localparam int BROWNOUT_TRIP_SELECT_BIT     = 10;
   localparam int STK_BIT      = 9;
   localparam int WRT_LSB      = 0;
   // Self-write guard limits
   localparam logic [14:0] GUARD_LIM_10 = 15'h01ff;
   localparam logic [14:0] GUARD_LIM_01 = 15'h03ff;
   localparam logic [14:0] GUARD_LIM_00 = 15'h07ff;
   // APB register map (byte addresses)
   localparam logic [15:0] REG_CFG_ONE    = 16'h0000;
   localparam logic [15:0] REG_CFG_TWO    = 16'h0004;
   localparam logic [15:0] REG_USER_ID    = 16'h0010;
   localparam logic [15:0] REG_STATUS     = 16'h0020;
   localparam logic [15:0] REG_PROBE      = 16'h0024;
   localparam logic [15:0] REG_PROBE_RES  = 16'h0028;
   localparam logic [13:0] USER_ID_RESET  = 14'h3fff;

   typedef enum logic [1:0] {
      MODE_OFF, MODE_SOFT, MODE_RUN_ONLY, MODE_ALWAYS
   } mode_t;
   typedef enum logic [1:0] {
      OSC_INTERNAL, OSC_EXT_LOW, OSC_EXT_MEDIUM, OSC_EXT_HIGH
   } osc_t;
endpackage

// file: rtl/config_word_protection_decode.sv
// Configuration word store, decode and program-memory protection
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

// How it works
// RULE_01: Word one lives at 8007h, word two at 8008h.
// RULE_02: Blank or bulk-erased words read as all ones.
// RULE_03: Unimplemented configuration bits always read back as one.
// RULE_04: Word one bit 11 one gives I/O pin, zero gives clock output.
// RULE_05: Brown-out mode 11 always, 10 run only, 01 software, 00 off.
// RULE_06: Brown-out enable never turns on the power-up timer.
// RULE_07: Word one bit 7 zero enables code protection.
// RULE_08: Code protection clears only through bulk erase.
// RULE_09: While protected, external writes are blocked and reads give zeros.
// RULE_10: Processor fetch and internal reads ignore code protection.
// RULE_11: Reset-pin bit ignored with low-voltage programming; one means reset.
// RULE_12: Bit zero without low-voltage mode: digital input, pull-up by bit.
// RULE_13: Word one bit 5 zero enables the power-up timer.
// RULE_14: Watchdog mode 11 always, 10 run only, 01 software, 00 off.
// RULE_15: Oscillator 11 high, 10 medium, 01 low external, 00 internal.
// RULE_16: Word two bit 13 one permits low-voltage programming entry.
// RULE_17: Low-voltage bit cannot be zeroed when entered by low voltage.
// RULE_18: Word two bit 11 zero enables low-power brown-out.
// RULE_19: Word two bit 10 one selects low trip, zero high trip.
// RULE_20: Word two bit 9 one lets stack faults reset the device.
// RULE_21: Self-write guard protects 1FFh, 3FFh, 7FFh or nothing.
// RULE_22: Four user ID words at 8000h to 8003h stay accessible.
// RULE_23: Settings latch at reset and hold until the next reset.
module config_word_protection_decode
   import cfg_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                clk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [15:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                ext_prog_active,
   input  wire logic                lvp_entry,
   input  wire logic                bulk_erase,
   input  wire logic [15:0]         ext_addr,
   input  wire logic                ext_wr_en,
   input  wire logic [13:0]         ext_wdata,
   input  wire logic                ext_rd_en,
   input  wire logic [13:0]         ext_mem_rdata,
   output logic      [13:0]         ext_rdata,
   output logic                     ext_mem_wr_allow,
   output logic                     ext_wr_refused,
   input  wire logic                cpu_rd_en,
   input  wire logic [13:0]         cpu_mem_rdata,
   output logic      [13:0]         cpu_rdata,
   input  wire logic                soft_brownout_on,
   input  wire logic                soft_watchdog_on,
   input  wire logic                reset_pin_pullup_on,
   input  wire logic                in_sleep,
   output logic                     clock_out_on,
   output logic                     brownout_active,
   output mode_t                    brownout_mode,
   output logic                     powerup_timer_on,
   output logic                     watchdog_active,
   output mode_t                    watchdog_mode,
   output osc_t                     oscillator_select,
   output logic                     clock_input_pin_io,
   output logic                     master_clear_pin_reset,
   output logic                     master_clear_pin_pullup,
   output logic                     low_power_brownout_on,
   output logic                     brownout_trip_low,
   output logic                     stack_fault_reset_on,
   output logic                     code_protect_on,
   output logic                     low_voltage_prog_on
);
   import cfg_pkg::*;

   // Stored (nonvolatile) words and the reset-time copies
   logic [13:0] nv_one_q, nv_two_q;
   logic [13:0] act_one_q, act_two_q;
   logic        load_pend_q;
   logic [13:0] user_id_q [4];
   logic [14:0] probe_addr_q;
   logic        probe_block_q;
   logic        ext_wr_refused_q;

   // Read views, fixed bits forced high
   logic [13:0] rd_one, rd_two;
   assign rd_one = nv_one_q | CFG_ONE_FIXED;  // see RULE_03
   assign rd_two = nv_two_q | CFG_TWO_FIXED;  // see RULE_03

   logic ext_prot;
   assign ext_prot = ~nv_one_q[CP_BIT];  // see RULE_07

   logic ext_hit_one, ext_hit_two, ext_hit_id, ext_pm;
   assign ext_hit_one = ext_addr == ADDR_CFG_ONE;  // see RULE_01
   assign ext_hit_two = ext_addr == ADDR_CFG_TWO;  // see RULE_01
   assign ext_hit_id  = ext_addr >= ADDR_USER_ID0 &&
                        ext_addr <= ADDR_USER_ID3;  // see RULE_22
   assign ext_pm      = ~ext_addr[15];

   logic [13:0] one_wr;
   logic [13:0] two_wr;
   always_comb begin
      one_wr = ext_wdata & nv_one_q;
      // Flash programming only clears bits; a cleared CP stays cleared
      two_wr = ext_wdata & nv_two_q;
      if (lvp_entry) begin
         two_wr[LVP_BIT] = nv_two_q[LVP_BIT];  // see RULE_17
      end
   end

   // Nonvolatile words keep their content across resets, so a reset
   // really loads the programmed settings; only bulk erase gives ones
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         if (bulk_erase) begin
            nv_one_q <= CFG_BLANK;  // see RULE_08
            nv_two_q <= CFG_BLANK;  // see RULE_02
         end else if (ext_prog_active && ext_wr_en) begin
            if (ext_hit_one) begin
               nv_one_q <= one_wr;  // see RULE_08
            end else if (ext_hit_two) begin
               nv_two_q <= two_wr;
            end
         end
      end
   end

   // Decoded settings load once after reset release and then stay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_pend_q <= 1'b1;
         act_one_q   <= CFG_BLANK;
         act_two_q   <= CFG_BLANK;
      end else if (clk_en && load_pend_q) begin
         load_pend_q <= 1'b0;  // see RULE_23
         act_one_q   <= rd_one;
         act_two_q   <= rd_two;
      end
   end

   // Decode of the held words into device settings
   logic lvp_on;
   assign lvp_on = act_two_q[LVP_BIT];  // see RULE_16
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_out_on            <= 1'b0;
         brownout_mode           <= MODE_ALWAYS;
         brownout_active         <= 1'b1;
         powerup_timer_on        <= 1'b0;
         watchdog_mode           <= MODE_ALWAYS;
         watchdog_active         <= 1'b1;
         oscillator_select       <= OSC_EXT_HIGH;
         clock_input_pin_io      <= 1'b0;
         master_clear_pin_reset  <= 1'b1;
         master_clear_pin_pullup <= 1'b1;
         low_power_brownout_on   <= 1'b0;
         brownout_trip_low       <= 1'b1;
         stack_fault_reset_on    <= 1'b1;
         code_protect_on         <= 1'b0;
         low_voltage_prog_on     <= 1'b1;
      end else if (clk_en) begin
         clock_out_on  <= ~act_one_q[CLOCK_OUTPUT_PIN_BIT];  // see RULE_04
         brownout_mode <= mode_t'(act_one_q[BOR_LSB +: 2]);  // see RULE_05
         case (mode_t'(act_one_q[BOR_LSB +: 2]))
            MODE_ALWAYS:   brownout_active <= 1'b1;
            MODE_RUN_ONLY: brownout_active <= ~in_sleep;
            MODE_SOFT:     brownout_active <= soft_brownout_on;
            default:       brownout_active <= 1'b0;
         endcase
         // Timer follows its own bit only, not brown-out
         powerup_timer_on <= ~act_one_q[POWERUP_TIMER_BIT];  // see RULE_06 RULE_13
         watchdog_mode <= mode_t'(act_one_q[WDT_LSB +: 2]);  // see RULE_14
         case (mode_t'(act_one_q[WDT_LSB +: 2]))
            MODE_ALWAYS:   watchdog_active <= 1'b1;
            MODE_RUN_ONLY: watchdog_active <= ~in_sleep;
            MODE_SOFT:     watchdog_active <= soft_watchdog_on;
            default:       watchdog_active <= 1'b0;
         endcase
         oscillator_select <= osc_t'(act_one_q[OSC_LSB +: 2]);  // see RULE_15
         clock_input_pin_io <= act_one_q[OSC_LSB +: 2] == 2'b00;  // see RULE_15
         if (lvp_on || act_one_q[RSTPIN_BIT]) begin
            master_clear_pin_reset  <= 1'b1;  // see RULE_11
            master_clear_pin_pullup <= 1'b1;
         end else begin
            master_clear_pin_reset  <= 1'b0;  // see RULE_12
            master_clear_pin_pullup <= reset_pin_pullup_on;
         end
         low_power_brownout_on <= ~act_two_q[LOW_POWER_BROWNOUT_OFF_BIT];  // see RULE_18
         brownout_trip_low     <= act_two_q[BROWNOUT_TRIP_SELECT_BIT];  // see RULE_19
         stack_fault_reset_on  <= act_two_q[STK_BIT];  // see RULE_20
         code_protect_on       <= ~act_one_q[CP_BIT];  // see RULE_07
         low_voltage_prog_on   <= lvp_on;  // see RULE_16
      end
   end

   // External access port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_rdata        <= '0;
         ext_mem_wr_allow <= 1'b0;
         ext_wr_refused_q <= 1'b0;
      end else if (clk_en) begin
         ext_mem_wr_allow <= ext_prog_active && ext_wr_en && ext_pm &&
                             !ext_prot;  // see RULE_09
         ext_wr_refused_q <= ext_prog_active && ext_wr_en &&
                             ((ext_pm && ext_prot) ||
                              (ext_hit_two && lvp_entry &&
                               !ext_wdata[LVP_BIT]));  // see RULE_17
         if (ext_rd_en) begin
            if (ext_hit_one) begin
               ext_rdata <= rd_one;
            end else if (ext_hit_two) begin
               ext_rdata <= rd_two;
            end else if (ext_hit_id) begin
               ext_rdata <= user_id_q[ext_addr[1:0]];
            end else if (ext_pm && !ext_prot) begin
               ext_rdata <= ext_mem_rdata;
            end else begin
               ext_rdata <= '0;  // see RULE_09
            end
         end
      end
   end
   assign ext_wr_refused = ext_wr_refused_q;

   // Processor reads pass untouched by code protection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_rdata <= '0;
      end else if (clk_en && cpu_rd_en) begin
         cpu_rdata <= cpu_mem_rdata;  // see RULE_10
      end
   end

   // Self-write guard probe: software writes an address, reads verdict
   logic guard_hit;
   always_comb begin
      case (act_two_q[WRT_LSB +: 2])
         2'b10:   guard_hit = probe_addr_q <= GUARD_LIM_10;  // see RULE_21
         2'b01:   guard_hit = probe_addr_q <= GUARD_LIM_01;
         2'b00:   guard_hit = probe_addr_q <= GUARD_LIM_00;
         default: guard_hit = 1'b0;
      endcase
   end

   // APB slave, one wait state in each access phase
   logic apb_wr, apb_rd;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;
   logic id_hit;
   assign id_hit = paddr >= REG_USER_ID &&
                   paddr < REG_USER_ID + 16'h0010 && paddr[1:0] == 2'b00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         probe_addr_q  <= '0;
         probe_block_q <= 1'b0;
      end else if (clk_en) begin
         probe_block_q <= guard_hit;
         if (apb_wr && pready && paddr == REG_PROBE) begin
            probe_addr_q <= pwdata[14:0];
         end
      end
   end

   generate
      for (genvar i = 0; i < 4; i++) begin : g_uid
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               user_id_q[i] <= USER_ID_RESET;
            end else if (clk_en) begin
               if (bulk_erase) begin
                  user_id_q[i] <= USER_ID_RESET;
               end else if (apb_wr && pready && id_hit &&
                            paddr[3:2] == i[1:0]) begin
                  user_id_q[i] <= pwdata[13:0];  // see RULE_22
               end else if (ext_prog_active && ext_wr_en && ext_hit_id &&
                            ext_addr[1:0] == i[1:0]) begin
                  user_id_q[i] <= ext_wdata;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (clk_en) begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && penable && !pready) begin
            if (paddr == REG_CFG_ONE) begin
               prdata <= {18'h0, rd_one};
               pslverr <= pwrite;
            end else if (paddr == REG_CFG_TWO) begin
               prdata <= {18'h0, rd_two};
               pslverr <= pwrite;
            end else if (id_hit) begin
               prdata <= {18'h0, user_id_q[paddr[3:2]]};
            end else if (paddr == REG_STATUS) begin
               prdata <= {28'h0, lvp_entry, ext_prot, load_pend_q,
                          ext_wr_refused_q};
               pslverr <= pwrite;
            end else if (paddr == REG_PROBE) begin
               prdata <= {17'h0, probe_addr_q};
            end else if (paddr == REG_PROBE_RES) begin
               prdata <= {31'h0, probe_block_q};
               pslverr <= pwrite;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Checks
   a_rd_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && ext_rd_en && ext_pm && ext_prot |=> ext_rdata == 14'h0)
      else $error("protected read not zero");  // see RULE_09
   a_wr_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && ext_wr_en && ext_pm && ext_prot |=> !ext_mem_wr_allow)
      else $error("protected write allowed");  // see RULE_09
   a_cp_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      !nv_one_q[CP_BIT] && !bulk_erase |=> !nv_one_q[CP_BIT])
      else $error("code protect cleared without erase");  // see RULE_08
   a_fixed_ones: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_one & CFG_ONE_FIXED) == CFG_ONE_FIXED &&
      (rd_two & CFG_TWO_FIXED) == CFG_TWO_FIXED)
      else $error("unimplemented bit low");  // see RULE_03
   a_settings_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !load_pend_q |=> $stable(act_one_q) && $stable(act_two_q))
      else $error("settings changed without reset");  // see RULE_23
   a_lvp_keep: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && lvp_entry && !bulk_erase && nv_two_q[LVP_BIT]
      |=> nv_two_q[LVP_BIT])
      else $error("low voltage bit cleared");  // see RULE_17
   a_cpu_pass: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && cpu_rd_en |=> cpu_rdata == $past(cpu_mem_rdata))
      else $error("cpu read altered");  // see RULE_10
   a_pin_reset: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && lvp_on |=> master_clear_pin_reset)
      else $error("reset pin lost with low voltage");  // see RULE_11
   a_erase_blank: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && bulk_erase |=> nv_one_q == CFG_BLANK && nv_two_q == CFG_BLANK)
      else $error("erase did not blank");  // see RULE_02
   c_prot_read: cover property (@(posedge pclk) ext_rd_en && ext_prot);
   c_erase: cover property (@(posedge pclk) bulk_erase && ext_prot);
   c_apb_rd: cover property (@(posedge pclk) apb_rd && pready);
endmodule
